// *** src/srld_pkg.sv ***
// ************************************************************
// shared constants and types
// ************************************************************
package srld_pkg;
  // register byte addresses, one aligned word each
  localparam logic [7:0] SRLD_CTRL_ADR   = 8'h00;
  localparam logic [7:0] SRLD_SPCMD_ADR  = 8'h04;
  localparam logic [7:0] SRLD_LIMLO_ADR  = 8'h08;
  localparam logic [7:0] SRLD_LIMHI_ADR  = 8'h0C;
  localparam logic [7:0] SRLD_RATE_ADR   = 8'h10;
  localparam logic [7:0] SRLD_PERIOD_ADR = 8'h14;
  localparam logic [7:0] SRLD_GAINA_ADR  = 8'h18;
  localparam logic [7:0] SRLD_GAINB_ADR  = 8'h1C;
  localparam logic [7:0] SRLD_GAINC_ADR  = 8'h20;
  localparam logic [7:0] SRLD_DBAND_ADR  = 8'h24;
  localparam logic [7:0] SRLD_STAT_ADR   = 8'h28;
  localparam logic [7:0] SRLD_WORK_ADR   = 8'h2C;
  localparam logic [7:0] SRLD_VALVE_ADR  = 8'h30;
  // reset values; limits default to the full measuring range
  localparam logic [15:0] SRLD_CTRL_RST   = 16'h001E;
  localparam logic [15:0] SRLD_LIMLO_RST  = 16'h0000;
  localparam logic [15:0] SRLD_LIMHI_RST  = 16'hFFFF;
  localparam logic [15:0] SRLD_RATE_RST   = 16'h0100;
  localparam logic [15:0] SRLD_PERIOD_RST = 16'h03E8;
  localparam logic [15:0] SRLD_GAIN_RST   = 16'h0004;
  // status bit positions
  localparam int SRLD_ST_REJECT = 0;
  localparam int SRLD_ST_INBAND = 1;
  localparam int SRLD_ST_RAMP   = 2;
  // timing: one update tick per millisecond
  localparam int SRLD_CLK_NS      = 10;
  localparam int SRLD_TICK_NS     = 1_000_000;
  localparam int SRLD_TICK_CYC    = SRLD_TICK_NS / SRLD_CLK_NS;
  localparam logic [15:0] SRLD_SEC_MS = 16'h03E8;
  // valve percentage scale
  localparam logic [6:0] SRLD_PCT_FULL = 7'h64;
  // controlled variable choice
  typedef enum logic [1:0] {
    SRLD_VAR_ABS   = 2'b00,
    SRLD_VAR_GAUGE = 2'b01,
    SRLD_VAR_DIFF  = 2'b10,
    SRLD_VAR_VALVE = 2'b11
  } srld_var_e;
  // control word layout, msb first
  typedef struct packed {
    logic [3:0] spare;      // reads zero
    logic [1:0] show;       // 00 none 01 screen 10 serial 11 both
    srld_var_e  ctrl_var;   // controlled variable
    logic       alg_sq;     // 1 squared derivative loop
    logic       band_close; // 1 close valve in band, 0 hold
    logic       rate_mode;  // 1 rate by change over period
    logic       zero_ramp;  // 1 ramp toward zero
    logic       pwr_ramp;   // 1 ramp from zero at power up
    logic       ramp_dn;    // downward ramping on
    logic       ramp_up;    // upward ramping on
    logic       src_analog; // 1 analog setpoint input
  } srld_cfg_s;
endpackage

// *** src/srld_top.sv ***
// What this block does
// - ramp starts from zero after power up
// - power-up no-ramp jumps straight to target
// - hold limits, default full measuring range
// - refuse out-of-limit serial setpoint, flag error
// - clamp analog setpoint to nearest limit
// - limits stored as fraction of full scale
// - select pressure kind or valve drive
// - select pseudo or squared derivative loop
// - pseudo loop: D proportional, P integral
// - squared loop adds squared derivative damping
// - zero deadband disables it
// - band arms at setpoint, releases at edge
// - in band hold or close valve
// - rate per second or change per period
// - upward ramp off means immediate rise
// - downward ramp off means immediate fall
// - zero setpoint no-ramp snaps at once
// - valve drive reported as percentage
// - two-bit valve display mode select
`timescale 1ns/1ns
`default_nettype none
module srld_top
  import srld_pkg::*;
#(
  parameter int TICK_CYC = SRLD_TICK_CYC    // cycles per update tick
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] analog_sp_i,
  input  wire logic [15:0] pv_abs_i,
  input  wire logic [15:0] pv_gauge_i,
  input  wire logic [15:0] pv_diff_i,
  output logic      [15:0] valve_drive_o,
  output logic      [6:0]  valve_pct_o,
  output logic             show_screen_o,
  output logic             show_serial_o,
  output logic             sp_reject_o,
  output logic      [15:0] work_sp_o
);
  import srld_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // merge low two byte lanes into a 16-bit register
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  // saturate a signed value into the unsigned 16-bit range
  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v < 48'sd0) begin
      sat16 = 16'h0000;
    end else if (v > 48'sd65535) begin
      sat16 = 16'hFFFF;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  logic [15:0] ctrl_reg;      // control word
  logic [15:0] limlo_reg;     // lower limit, fraction of full scale
  logic [15:0] limhi_reg;     // upper limit, fraction of full scale
  logic [15:0] rate_reg;      // units per second, or change per period
  logic [15:0] period_reg;    // period in ticks for change mode
  logic [15:0] gaina_reg;     // pseudo: D / squared: P
  logic [15:0] gainb_reg;     // pseudo: P / squared: I
  logic [15:0] gainc_reg;     // squared: D
  logic [15:0] dband_reg;     // deadband half width
  logic [15:0] target_reg;    // limited target setpoint
  logic [15:0] work_reg;      // ramped working setpoint
  logic        reject_reg;    // sticky refused command
  logic        rej_pulse_reg; // one-cycle refused pulse
  logic        pwr_reg;       // power-up ramp still pending
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        in_band_reg;   // deadband active, read by status
  logic [6:0]  pct_reg;       // valve percentage, read by bus
  srld_cfg_s   cfg;
  assign cfg = ctrl_reg;

  // ************************************************************
  // wishbone slave, one wait cycle, write at the ack edge
  // ************************************************************
  wire req      = wb_cyc_i & wb_stb_i;
  wire wr_fire  = req & ack_reg & wb_we_i;
  wire sel_ctrl = wr_fire & (wb_adr_i == SRLD_CTRL_ADR);
  wire sel_sp   = wr_fire & (wb_adr_i == SRLD_SPCMD_ADR);
  wire sel_stat = wr_fire & (wb_adr_i == SRLD_STAT_ADR);
  wire [15:0] sp_cmd = lane16(target_reg, wb_dat_i, wb_sel_i);
  wire [15:0] ctrl_wr = lane16(ctrl_reg, wb_dat_i, wb_sel_i);
  // range test on the serial request
  wire sp_bad = (sp_cmd < limlo_reg) | (sp_cmd > limhi_reg);
  logic [15:0] rd16;

  // read mux; unmapped addresses read zero
  always_comb begin
    unique case (wb_adr_i)
      SRLD_CTRL_ADR:   rd16 = {4'h0, ctrl_reg[11:0]};
      SRLD_SPCMD_ADR:  rd16 = target_reg;
      SRLD_LIMLO_ADR:  rd16 = limlo_reg;
      SRLD_LIMHI_ADR:  rd16 = limhi_reg;
      SRLD_RATE_ADR:   rd16 = rate_reg;
      SRLD_PERIOD_ADR: rd16 = period_reg;
      SRLD_GAINA_ADR:  rd16 = gaina_reg;
      SRLD_GAINB_ADR:  rd16 = gainb_reg;
      SRLD_GAINC_ADR:  rd16 = gainc_reg;
      SRLD_DBAND_ADR:  rd16 = dband_reg;
      SRLD_STAT_ADR:   rd16 = {13'h0000, work_reg != target_reg, in_band_reg, reject_reg};
      SRLD_WORK_ADR:   rd16 = work_reg;
      SRLD_VALVE_ADR:  rd16 = {9'h000, pct_reg};
      default:         rd16 = 16'h0000;
    endcase
  end

  // ack rises one cycle after the request, drops the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= req & ~ack_reg;
      rdat_reg <= {16'h0000, rd16};
    end
  end

  // kept as fractions, shared by every variable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg   <= SRLD_CTRL_RST;
      limlo_reg  <= SRLD_LIMLO_RST;
      limhi_reg  <= SRLD_LIMHI_RST;
      rate_reg   <= SRLD_RATE_RST;
      period_reg <= SRLD_PERIOD_RST;
      gaina_reg  <= SRLD_GAIN_RST;
      gainb_reg  <= SRLD_GAIN_RST;
      gainc_reg  <= 16'h0000;
      dband_reg  <= 16'h0000;
    end else if (wr_fire) begin
      // spare top nibble always stored as zero
      if (sel_ctrl) ctrl_reg <= {4'h0, ctrl_wr[11:0]};
      if (wb_adr_i == SRLD_LIMLO_ADR) limlo_reg <= lane16(limlo_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == SRLD_LIMHI_ADR) limhi_reg <= lane16(limhi_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == SRLD_RATE_ADR) rate_reg <= lane16(rate_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == SRLD_PERIOD_ADR) period_reg <= lane16(period_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == SRLD_GAINA_ADR) gaina_reg <= lane16(gaina_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == SRLD_GAINB_ADR) gainb_reg <= lane16(gainb_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == SRLD_GAINC_ADR) gainc_reg <= lane16(gainc_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == SRLD_DBAND_ADR) dband_reg <= lane16(dband_reg, wb_dat_i, wb_sel_i);
    end
  end

  // ************************************************************
  // analog setpoint input, three flops, accept when stable
  // ************************************************************
  logic [15:0] ana_s1_reg;
  logic [15:0] ana_s2_reg;
  logic [15:0] ana_s3_reg;
  logic [15:0] ana_reg;
  // pin crosses clock domain; stage one feeds only stage two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_s1_reg <= 16'h0000;
      ana_s2_reg <= 16'h0000;
      ana_s3_reg <= 16'h0000;
      ana_reg    <= 16'h0000;
    end else begin
      ana_s1_reg <= analog_sp_i;
      ana_s2_reg <= ana_s1_reg;
      ana_s3_reg <= ana_s2_reg;
      if (ana_s2_reg == ana_s3_reg) ana_reg <= ana_s3_reg;
    end
  end
  wire [15:0] ana_lim = (ana_reg < limlo_reg) ? limlo_reg :
                        (ana_reg > limhi_reg) ? limhi_reg : ana_reg;

  // ************************************************************
  // target setpoint and refusal flag
  // ************************************************************
  wire sp_take = sel_sp & ~cfg.src_analog & ~sp_bad;
  wire sp_refuse = sel_sp & ~cfg.src_analog & sp_bad;
  // analog source overrides; serial writes then have no effect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_reg    <= 16'h0000;
      reject_reg    <= 1'b0;
      rej_pulse_reg <= 1'b0;
    end else begin
      if (cfg.src_analog) begin
        target_reg <= ana_lim;
      end else if (sp_take) begin
        target_reg <= sp_cmd;
      end
      // refused command sets sticky error, set beats clear
      rej_pulse_reg <= sp_refuse;
      if (sp_refuse) begin
        reject_reg <= 1'b1;
      end else if (sel_stat & wb_sel_i[0] & wb_dat_i[SRLD_ST_REJECT]) begin
        reject_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // update tick and ramp period counter
  // ************************************************************
  logic [31:0] tick_cnt_reg;
  logic [15:0] per_cnt_reg;
  wire         tick = (tick_cnt_reg == 32'(TICK_CYC - 1));
  // per-second mode uses a fixed one-second period
  wire [15:0]  per_len = cfg.rate_mode ? ((period_reg == 16'h0000) ? 16'h0001 : period_reg) : SRLD_SEC_MS;
  wire         ramp_tick = tick & (per_cnt_reg >= per_len - 16'h0001);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 32'h0000_0000;
      per_cnt_reg  <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
      if (ramp_tick) begin
        per_cnt_reg <= 16'h0000;
      end else if (tick) begin
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      end
    end
  end

  // ************************************************************
  // ramp generator
  // ************************************************************
  wire        going_up = target_reg > work_reg;
  wire        going_dn = target_reg < work_reg;
  wire [15:0] gap = going_up ? target_reg - work_reg : work_reg - target_reg;
  wire jump = (going_up & ~cfg.ramp_up) | (going_dn & ~cfg.ramp_dn) |
              ((target_reg == 16'h0000) & ~cfg.zero_ramp) | (pwr_reg & ~cfg.pwr_ramp);
  logic [15:0] work_next;
  // step at most one rate per period, clipped at target
  always_comb begin
    work_next = work_reg;
    if (jump) begin
      work_next = target_reg;
    end else if (ramp_tick) begin
      if (gap <= rate_reg) begin
        work_next = target_reg;
      end else if (going_up) begin
        work_next = work_reg + rate_reg;
      end else begin
        work_next = work_reg - rate_reg;
      end
    end
  end
  // working setpoint starts at zero, stored value ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      work_reg <= 16'h0000;
      pwr_reg  <= 1'b1;
    end else begin
      work_reg <= work_next;
      // pending until a non-zero target is reached; the zero reset target must not use it up
      if ((work_reg == target_reg) && (target_reg != 16'h0000)) pwr_reg <= 1'b0;
    end
  end

  // ************************************************************
  // control loop
  // ************************************************************
  logic [15:0] drive_reg;
  logic [15:0] pv_prev_reg;
  logic signed [31:0] integ_reg;
  logic        e_neg_reg;
  logic [15:0] pv;
  // process value picked by the controlled variable
  always_comb begin
    unique case (cfg.ctrl_var)
      SRLD_VAR_ABS:   pv = pv_abs_i;
      SRLD_VAR_GAUGE: pv = pv_gauge_i;
      SRLD_VAR_DIFF:  pv = pv_diff_i;
      SRLD_VAR_VALVE: pv = drive_reg;
    endcase
  end
  wire signed [47:0] err  = $signed({32'h0000_0000, work_reg}) - $signed({32'h0000_0000, pv});
  wire signed [47:0] derr = $signed({32'h0000_0000, pv}) - $signed({32'h0000_0000, pv_prev_reg});
  wire signed [47:0] aerr = err[47] ? -err : err;
  wire signed [47:0] ade  = derr[47] ? -derr : derr;
  // larger D shifts the proportional term down
  wire signed [47:0] p_pseudo = err >>> gaina_reg[3:0];
  wire signed [47:0] p_sq = (err * $signed({32'h0000_0000, gaina_reg})) >>> 8;
  wire signed [47:0] de2  = (derr * ade) >>> 8;
  wire signed [47:0] d_sq = (de2 * $signed({32'h0000_0000, gainc_reg})) >>> 8;
  wire signed [47:0] i_add = (err * $signed({32'h0000_0000, gainb_reg})) >>> 12;
  wire [15:0] integ_new = sat16(48'(integ_reg) + i_add);
  // algorithm chosen by the control word
  wire signed [47:0] u = cfg.alg_sq ? 48'(integ_reg) + p_sq - d_sq : 48'(integ_reg) + p_pseudo;
  // symmetric window about the working setpoint
  wire at_edge = aerr >= $signed({32'h0000_0000, dband_reg});
  // armed on reaching or crossing the setpoint
  wire reached = (err == 48'sd0) | (err[47] != e_neg_reg);
  wire band_next = (dband_reg != 16'h0000) & (in_band_reg ? ~at_edge : (reached & ~at_edge));

  // loop runs once per tick; integrator frozen while in band
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_reg   <= 16'h0000;
      pv_prev_reg <= 16'h0000;
      integ_reg   <= 32'sd0;
      in_band_reg <= 1'b0;
      e_neg_reg   <= 1'b0;
    end else if (tick) begin
      pv_prev_reg <= pv;
      e_neg_reg   <= err[47];
      in_band_reg <= band_next;
      // hold or close while in band
      if (band_next) begin
        if (cfg.band_close) drive_reg <= 16'h0000;
      end else begin
        integ_reg <= $signed({16'h0000, integ_new});
        drive_reg <= sat16(u);
      end
    end
  end

  // ************************************************************
  // reporting outputs
  // ************************************************************
  // closed valve reads 0 percent, as does any drive under 1 percent
  wire [22:0] pct_mul = 23'(drive_reg) * 23'(SRLD_PCT_FULL);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pct_reg       <= 7'h00;
      show_screen_o <= 1'b0;
      show_serial_o <= 1'b0;
    end else begin
      pct_reg       <= pct_mul[22:16];
      show_screen_o <= cfg.show[0];
      show_serial_o <= cfg.show[1];
    end
  end
  assign wb_ack_o      = ack_reg;
  assign wb_dat_o      = rdat_reg;
  assign valve_drive_o = drive_reg;
  assign valve_pct_o   = pct_reg;
  assign sp_reject_o   = rej_pulse_reg;
  assign work_sp_o     = work_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  start_zero_a: assert property ($fell(rst_i) |-> work_reg == 16'h0000) else $error("ramp not from zero");
  pwr_jump_a: assert property (pwr_reg && !cfg.pwr_ramp |=> work_reg == $past(target_reg)) else $error("power jump missed");
  reject_keep_a: assert property (sp_refuse |=> target_reg == $past(target_reg) && reject_reg && sp_reject_o) else $error("bad setpoint taken");
  ana_clamp_a: assert property (cfg.src_analog && limlo_reg <= limhi_reg |=> target_reg >= $past(limlo_reg) && target_reg <= $past(limhi_reg)) else $error("analog not clamped");
  ramp_bound_a: assert property (!jump && ramp_tick && going_up |=> work_reg <= $past(target_reg) && work_reg - $past(work_reg) <= $past(rate_reg)) else $error("ramp step too large");
  ramp_hold_a: assert property (!jump && !ramp_tick |=> $stable(work_reg)) else $error("work moved off tick");
  up_jump_a: assert property (going_up && !cfg.ramp_up |=> work_reg == $past(target_reg)) else $error("up ramp not bypassed");
  dn_jump_a: assert property (going_dn && !cfg.ramp_dn |=> work_reg == $past(target_reg)) else $error("down ramp not bypassed");
  band_off_a: assert property (dband_reg == 16'h0000 && tick |=> !in_band_reg) else $error("band on at zero width");
  band_close_a: assert property (tick && band_next && cfg.band_close |=> drive_reg == 16'h0000) else $error("valve not closed in band");
  pct_zero_a: assert property (drive_reg == 16'h0000 ##1 drive_reg == 16'h0000 |-> valve_pct_o == 7'h00) else $error("closed valve not 0 pct");
  ramp_seen_c: cover property (ramp_tick && !jump && going_up ##1 work_reg != target_reg);
  reject_seen_c: cover property (sp_refuse);
  band_seen_c: cover property (!in_band_reg ##1 in_band_reg);
endmodule
`default_nettype wire

// *** sim/srld_plant_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// chamber and analog setpoint source model
// ************************************************************
module srld_plant_model (
  input  wire logic        clk_i,      // block clock
  input  wire logic        rst_i,      // sync reset
  input  wire logic [15:0] drive_i,    // valve drive from block
  input  wire logic [15:0] knob_i,     // analog level set by bench
  output logic      [15:0] analog_o,   // analog setpoint wire
  output logic      [15:0] pv_abs_o,   // absolute pressure
  output logic      [15:0] pv_gauge_o, // gauge pressure
  output logic      [15:0] pv_diff_o   // differential pressure
);
  logic [15:0] press_reg; // chamber pressure, lags the valve
  // first order lag so the loop always sees some error
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      press_reg <= 16'h0000;
    end else if (drive_i > press_reg) begin
      press_reg <= press_reg + ((drive_i - press_reg) >> 4);
    end else begin
      press_reg <= press_reg - ((press_reg - drive_i) >> 4);
    end
  end
  assign analog_o   = knob_i;
  assign pv_abs_o   = press_reg;
  assign pv_gauge_o = press_reg;
  assign pv_diff_o  = press_reg >> 1; // half range across the ports
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import srld_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic        clk_i  = 1'b0;  // 100 MHz
  logic        rst_i  = 1'b1;  // sync reset
  logic        wb_cyc = 1'b0;  // bus request
  logic        wb_we  = 1'b0;  // write strobe
  logic [7:0]  wb_adr = 8'h00; // byte address
  logic [3:0]  wb_sel = 4'h0;  // byte lanes
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [15:0] knob   = 16'h0000; // analog level asked
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, scr, ser, rej;
  logic [15:0] ana, pv_a, pv_g, pv_d, drive, work, rd, prv;
  logic [6:0]  pct;
  int          error_cnt   = 0;
  int          comparisons = 0;
  srld_top #(.TICK_CYC(10)) i_srld_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .analog_sp_i(ana), .pv_abs_i(pv_a), .pv_gauge_i(pv_g),
    .pv_diff_i(pv_d), .valve_drive_o(drive), .valve_pct_o(pct), .show_screen_o(scr),
    .show_serial_o(ser), .sp_reject_o(rej), .work_sp_o(work));
  srld_plant_model i_srld_plant_model (.clk_i(clk_i), .rst_i(rst_i), .drive_i(drive), .knob_i(knob),
    .analog_o(ana), .pv_abs_o(pv_a), .pv_gauge_o(pv_g), .pv_diff_o(pv_d));
  initial forever #5 clk_i = ~clk_i;
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; data is taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc, wb_we, wb_adr, wb_sel, wb_dat} <= {1'b1, w, a, 4'h3, 16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o[15:0];
    wb_cyc <= 1'b0;
    wb_we  <= 1'b0;
    chk("ack", 16'h0001, {15'h0000, wb_ack_o});
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    wb(1'b0, a, 16'h0000);
    chk(what, exp, rd);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rd_chk("ctrl", SRLD_CTRL_ADR, 16'h001E);
    rd_chk("limlo", SRLD_LIMLO_ADR, 16'h0000);
    rd_chk("limhi", SRLD_LIMHI_ADR, 16'hFFFF);
    rd_chk("rate", SRLD_RATE_ADR, 16'h0100);
    rd_chk("period", SRLD_PERIOD_ADR, 16'h03E8);
    wb(1'b1, 8'h3C, 16'h1234);
    rd_chk("unmapped", 8'h3C, 16'h0000);
    chk("work", 16'h0000, work);
    wb(1'b1, SRLD_CTRL_ADR, 16'h0016);
    wb(1'b1, SRLD_SPCMD_ADR, 16'h4000);
    repeat (3) @(posedge clk_i);
    chk("power jump", 16'h4000, work);
    $display("test reset done");
  endtask
  task automatic t_ramp();
    do_reset();
    wb(1'b1, SRLD_CTRL_ADR, 16'h003E);
    wb(1'b1, SRLD_PERIOD_ADR, 16'h0001);
    wb(1'b1, SRLD_SPCMD_ADR, 16'h0300);
    prv = 16'h0000;
    repeat (80) begin
      @(posedge clk_i);
      chk("ramp step", 16'h0001, 16'(work >= prv && work - prv <= 16'h0100 && work <= 16'h0300));
      prv = work;
    end
    chk("ramp end", 16'h0300, work);
    $display("test ramp done");
  endtask
  task automatic jump(input logic [15:0] c, input logic [15:0] sp, input string what);
    wb(1'b1, SRLD_CTRL_ADR, c);
    wb(1'b1, SRLD_SPCMD_ADR, sp);
    repeat (3) @(posedge clk_i);
    chk(what, sp, work);
  endtask
  task automatic t_jumps();
    jump(16'h001C, 16'h8000, "up jump");
    jump(16'h001A, 16'h1000, "down jump");
    jump(16'h000E, 16'h0000, "zero jump");
    $display("test jumps done");
  endtask
  task automatic t_reject();
    int hi;
    hi = 0;
    wb(1'b1, SRLD_LIMLO_ADR, 16'h1000);
    wb(1'b1, SRLD_LIMHI_ADR, 16'h2000);
    jump(16'h0018, 16'h1800, "in limits");
    wb(1'b1, SRLD_SPCMD_ADR, 16'h3000);
    repeat (3) begin
      @(posedge clk_i);
      hi += int'(rej === 1'b1);
    end
    chk("reject pulse", 16'h0001, 16'(hi));
    rd_chk("status", SRLD_STAT_ADR, 16'h0001);
    wb(1'b1, SRLD_STAT_ADR, 16'h0001);
    rd_chk("status clear", SRLD_STAT_ADR, 16'h0000);
    wb(1'b1, SRLD_SPCMD_ADR, 16'h0800);
    rd_chk("target kept", SRLD_SPCMD_ADR, 16'h1800);
    $display("test reject done");
  endtask
  task automatic t_analog();
    wb(1'b1, SRLD_CTRL_ADR, 16'h0019);
    knob <= 16'hF000;
    repeat (10) @(posedge clk_i);
    chk("clamp high", 16'h2000, work);
    knob <= 16'h0100;
    repeat (10) @(posedge clk_i);
    chk("clamp low", 16'h1000, work);
    wb(1'b1, SRLD_SPCMD_ADR, 16'h1800);
    repeat (3) @(posedge clk_i);
    chk("serial ignored", 16'h1000, work);
    wb(1'b1, SRLD_CTRL_ADR, 16'h0118);
    rd_chk("limit kept", SRLD_LIMHI_ADR, 16'h2000);
    $display("test analog done");
  endtask
  task automatic t_show();
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, SRLD_CTRL_ADR, 16'h0118 | 16'(s << 10));
      repeat (2) @(posedge clk_i);
      chk("show", 16'(s), {14'h0000, ser, scr});
    end
    $display("test show done");
  endtask
  task automatic t_pct();
    wb(1'b1, SRLD_SPCMD_ADR, 16'h1800);
    prv = drive;
    repeat (100) begin
      @(posedge clk_i);
      chk("pct", 16'((32'(prv) * 100) >> 16), {9'h000, pct});
      prv = drive;
    end
    chk("drive on", 16'h0001, 16'(drive != 16'h0000));
    $display("test pct done");
  endtask
  // valve as controlled variable, unity proportional, no integral
  task automatic t_band();
    logic seen;
    seen = 1'b0;
    do_reset();
    wb(1'b1, SRLD_GAINA_ADR, 16'h0000);
    wb(1'b1, SRLD_GAINB_ADR, 16'h0000);
    wb(1'b1, SRLD_DBAND_ADR, 16'h0100);
    wb(1'b1, SRLD_CTRL_ADR, 16'h0340);
    wb(1'b1, SRLD_SPCMD_ADR, 16'h1000);
    repeat (40) @(posedge clk_i);
    wb(1'b1, SRLD_CTRL_ADR, 16'h0300);
    repeat (60) @(posedge clk_i);
    chk("band hold", 16'h1000, drive);
    wb(1'b1, SRLD_DBAND_ADR, 16'h0000);
    repeat (30) begin
      @(posedge clk_i);
      seen = seen | (drive === 16'h0000);
    end
    chk("band off", 16'h0001, {15'h0000, seen});
    $display("test band done");
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    do_reset();
    t_reset();
    t_ramp();
    t_jumps();
    t_reject();
    t_analog();
    t_show();
    t_pct();
    t_band();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
